// ===== core/spm_serial_port.sv
// byte-wide full-duplex serial port, master or slave, with AXI4-Lite control and data registers
// assumes pins arrive asynchronously; the chip pad logic resolves the enables into wire levels
`timescale 1ns/100ps
`default_nettype none

module spm_serial_port
	import spm_pkg::*;
#(
	parameter int ADDR_W = 12
)
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sclkIn,
	output logic sclkOut,
	output logic sclkOe,
	input wire logic mosiIn,
	output logic mosiOut,
	output logic mosiOe,
	input wire logic misoIn,
	output logic misoOut,
	output logic misoOe,
	input wire logic slaveSelN,
	output logic portEnable,
	output logic transferDone
);

	if (ADDR_W < 10 || ADDR_W > 32)
	begin : addr_check
		$error("ADDR_W must hold the register byte addresses");
	end

	function automatic logic hitAddr(input logic [ADDR_W-1:0] addr, input logic [9:0] target);
		hitAddr = (addr[ADDR_W-1:2] == (ADDR_W-2)'(target[9:2]));
	endfunction

	// control fields
	logic portEnQ, masterQ, cpolQ, cphaQ;
	logic [1:0] rateQ;
	logic doneFlagQ, doneFlagD, wcolQ, wcolD;
	logic [7:0] txHoldQ, rxDataQ;

	// bus slave state
	logic awHeldQ, wHeldQ, bvalidQ, rvalidQ;
	logic [ADDR_W-1:0] awAddrQ;
	logic [7:0] wDataQ;
	logic wLane0Q;
	logic [1:0] brespQ, rrespQ;
	logic [7:0] rdataQ;

	// pin synchronisers: sclk, select, mosi, miso
	logic [3:0] pinRaw, metaQ, syncQ;
	logic sclkPrevQ, ssPrevQ;

	// shift engine
	spm_state_type stateQ, stateD;
	logic [3:0] bitCntQ, bitCntD;
	logic [7:0] txShQ, txShD, rxShQ, rxShD;
	logic outBitQ, outBitD;
	logic sclkGenQ, sclkGenD;
	logic [5:0] halfCntQ, halfCntD;
	logic [4:0] halfNumQ, halfNumD;
	logic [3:0] leadCntQ;
	logic [1:0] mSampDlyQ, mEndDlyQ;

	assign pinRaw = {sclkIn, slaveSelN, mosiIn, misoIn};

	for (genvar i = 0; i < 4; i++)
	begin : pin_sync
		always_ff @(posedge clk_sys)
		begin
			if (!rst_n)
			begin
				// select rests high; a low reset value would look like a select edge
				metaQ[i] <= (i == 2);
				syncQ[i] <= (i == 2);
			end
			else if (clkEn)
			begin
				metaQ[i] <= pinRaw[i];
				syncQ[i] <= metaQ[i];
			end
		end
	end

	wire sclkSync = syncQ[3];
	wire ssSync = syncQ[2];
	wire mosiSync = syncQ[1];
	wire misoSync = syncQ[0];

	// write channel: address and data caught in either order, answered after both
	assign s_axi_awready = ~awHeldQ & ~bvalidQ;
	assign s_axi_wready = ~wHeldQ & ~bvalidQ;
	assign s_axi_arready = ~rvalidQ;
	wire doWrite = awHeldQ & wHeldQ & ~bvalidQ;
	wire doRead = s_axi_arvalid & ~rvalidQ;
	wire wHitData = hitAddr(awAddrQ, SPM_DATA_ADDR);
	wire wHitCtrl = hitAddr(awAddrQ, SPM_CTRL_ADDR);
	wire rHitData = hitAddr(s_axi_araddr, SPM_DATA_ADDR);
	wire rHitCtrl = hitAddr(s_axi_araddr, SPM_CTRL_ADDR);
	wire wrData = doWrite & wHitData & wLane0Q;
	wire wrCtrl = doWrite & wHitCtrl & wLane0Q;
	wire rdData = clkEn & doRead & rHitData;

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			awHeldQ <= 1'b0;
			wHeldQ <= 1'b0;
			bvalidQ <= 1'b0;
			awAddrQ <= '0;
			wDataQ <= 8'h00;
			wLane0Q <= 1'b0;
			brespQ <= SPM_RESP_OKAY;
		end
		else if (clkEn)
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				awHeldQ <= 1'b1;
				awAddrQ <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wHeldQ <= 1'b1;
				wDataQ <= s_axi_wdata[7:0];
				wLane0Q <= s_axi_wstrb[0];
			end
			if (doWrite)
			begin
				awHeldQ <= 1'b0;
				wHeldQ <= 1'b0;
				bvalidQ <= 1'b1;
				brespQ <= (wHitData | wHitCtrl) ? SPM_RESP_OKAY : SPM_RESP_SLVERR;
			end
			else if (bvalidQ && s_axi_bready)
				bvalidQ <= 1'b0;
		end
	end

	// bit0 reports the select pin while in slave role
	wire [7:0] ctrlView = {doneFlagQ, wcolQ, portEnQ, masterQ, cpolQ, cphaQ, rateQ[1],
		(portEnQ & ~masterQ) ? ssSync : rateQ[0]};
	wire [7:0] readMux = rHitData ? rxDataQ : (rHitCtrl ? ctrlView : 8'h00);

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			rvalidQ <= 1'b0;
			rdataQ <= 8'h00;
			rrespQ <= SPM_RESP_OKAY;
		end
		else if (clkEn)
		begin
			if (doRead)
			begin
				rvalidQ <= 1'b1;
				rdataQ <= readMux;
				rrespQ <= (rHitData | rHitCtrl) ? SPM_RESP_OKAY : SPM_RESP_SLVERR;
			end
			else if (rvalidQ && s_axi_rready)
				rvalidQ <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalidQ;
	assign s_axi_bresp = brespQ;
	assign s_axi_rvalid = rvalidQ;
	assign s_axi_rdata = {24'h000000, rdataQ};
	assign s_axi_rresp = rrespQ;

	// engine event decode
	wire busy = (stateQ != SPM_IDLE);
	wire slaveMode = portEnQ & ~masterQ;
	wire masterMode = portEnQ & masterQ;
	wire slaveSel = slaveMode & ~ssSync;
	wire sclkRise = sclkSync & ~sclkPrevQ;
	wire sclkFall = ~sclkSync & sclkPrevQ;
	wire ssRise = ssSync & ~ssPrevQ;
	wire sLead = slaveSel & (cpolQ ? sclkFall : sclkRise);
	wire sTrail = slaveSel & (cpolQ ? sclkRise : sclkFall);

	wire [6:0] divSel = (rateQ == 2'h0) ? SPM_DIV_4 : (rateQ == 2'h1) ? SPM_DIV_8 :
		(rateQ == 2'h2) ? SPM_DIV_32 : SPM_DIV_64;
	wire [5:0] halfLim = divSel[6:1];
	wire halfTick = masterMode & (stateQ == SPM_RUN) & (halfCntQ == halfLim - 6'h01);
	wire mLead = halfTick & (sclkGenQ == cpolQ);
	wire mTrail = halfTick & (sclkGenQ != cpolQ);

	wire leadEv = masterMode ? mLead : sLead;
	wire trailEv = masterMode ? mTrail : sTrail;
	wire sampleEv = cphaQ ? trailEv : leadEv;
	wire launchEv = cphaQ ? leadEv : trailEv;
	wire inBit = masterQ ? misoSync : mosiSync;
	wire lastSample = sampleEv & (bitCntQ == SPM_LAST_BIT);

	wire masterStart = wrData & ~busy & masterMode;
	// miso reaches the engine two flops late, so master capture and completion trail the clock
	wire masterLastTick = halfTick & (halfNumQ == SPM_LAST_HALF);
	wire mSampleNow = masterMode & (cphaQ ? mTrail : mLead);
	wire masterDone = mEndDlyQ[1] & masterMode & (stateQ == SPM_WAIT_SS);
	wire rxShift = masterMode ? mSampDlyQ[1] : sampleEv;
	wire slaveDone = slaveMode & ((cphaQ & lastSample) | ((stateQ == SPM_WAIT_SS) & ssRise));
	wire byteDone = masterDone | slaveDone;
	wire slaveAbort = slaveMode & ssRise & (stateQ == SPM_RUN);

	always_comb
	begin
		stateD = stateQ;
		bitCntD = bitCntQ;
		txShD = txShQ;
		rxShD = rxShQ;
		outBitD = outBitQ;
		sclkGenD = sclkGenQ;
		halfCntD = halfCntQ;
		halfNumD = halfNumQ;
		if (masterStart)
		begin
			stateD = SPM_RUN;
			bitCntD = 4'h0;
			halfCntD = 6'h00;
			halfNumD = 5'h00;
			sclkGenD = cpolQ;
			outBitD = cphaQ ? outBitQ : wDataQ[7];
			txShD = cphaQ ? wDataQ : {wDataQ[6:0], 1'b0};
		end
		else if (!portEnQ || slaveAbort)
		begin
			stateD = SPM_IDLE;
			bitCntD = 4'h0;
			sclkGenD = cpolQ;
		end
		else
		begin
			// an idle clock follows a changed polarity setting one cycle later
			if (!busy)
				sclkGenD = cpolQ;
			if (masterMode && stateQ == SPM_RUN)
			begin
				halfCntD = halfTick ? 6'h00 : halfCntQ + 6'h01;
				if (halfTick)
				begin
					sclkGenD = ~sclkGenQ;
					halfNumD = halfNumQ + 5'h01;
				end
				if (masterLastTick)
					stateD = SPM_WAIT_SS;
			end
			if (launchEv)
			begin
				outBitD = txShQ[7];
				txShD = {txShQ[6:0], 1'b0};
			end
			if (rxShift)
				rxShD = {rxShQ[6:0], inBit};
			if (sampleEv)
				bitCntD = bitCntQ + 4'h1;
			if (slaveMode && stateQ == SPM_IDLE && leadEv)
				stateD = SPM_RUN;
			if (slaveMode && lastSample && !cphaQ)
				stateD = SPM_WAIT_SS;
			if (byteDone)
			begin
				stateD = SPM_IDLE;
				bitCntD = 4'h0;
			end
			// a fresh slave byte is staged only between bytes, so a colliding write cannot tear it
			if (slaveMode && stateD == SPM_IDLE && !leadEv)
			begin
				txShD = cphaQ ? txHoldQ : {txHoldQ[6:0], 1'b0};
				outBitD = cphaQ ? outBitQ : txHoldQ[7];
			end
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			stateQ <= SPM_IDLE;
			bitCntQ <= 4'h0;
			txShQ <= 8'h00;
			rxShQ <= 8'h00;
			outBitQ <= 1'b0;
			sclkGenQ <= 1'b0;
			halfCntQ <= 6'h00;
			halfNumQ <= 5'h00;
			sclkPrevQ <= 1'b0;
			ssPrevQ <= 1'b1;
			mSampDlyQ <= 2'h0;
			mEndDlyQ <= 2'h0;
		end
		else if (clkEn)
		begin
			stateQ <= stateD;
			bitCntQ <= bitCntD;
			txShQ <= txShD;
			rxShQ <= rxShD;
			outBitQ <= outBitD;
			sclkGenQ <= sclkGenD;
			halfCntQ <= halfCntD;
			halfNumQ <= halfNumD;
			sclkPrevQ <= sclkSync;
			ssPrevQ <= ssSync;
			mSampDlyQ <= {mSampDlyQ[0], mSampleNow};
			mEndDlyQ <= {mEndDlyQ[0], masterLastTick};
		end
	end

	// flags: a hardware set in the same cycle as a software clear wins
	wire doneClr = (wrCtrl & ~wDataQ[SPM_BIT_DONE]) | rdData;
	wire wcolClr = wrCtrl & ~wDataQ[SPM_BIT_WRITE_COLLISION_FLAG];
	wire wcolSet = wrData & busy;
	assign doneFlagD = byteDone | (doneFlagQ & ~doneClr);
	assign wcolD = wcolSet | (wcolQ & ~wcolClr);

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			{doneFlagQ, wcolQ, portEnQ, masterQ, cpolQ, cphaQ, rateQ} <= SPM_CTRL_RESET;
			txHoldQ <= SPM_DATA_RESET;
			rxDataQ <= SPM_DATA_RESET;
		end
		else if (clkEn)
		begin
			doneFlagQ <= doneFlagD;
			wcolQ <= wcolD;
			if (wrCtrl)
			begin
				portEnQ <= wDataQ[SPM_BIT_PEN];
				masterQ <= wDataQ[SPM_BIT_MST];
				cpolQ <= wDataQ[SPM_BIT_CLOCK_IDLE_LEVEL];
				cphaQ <= wDataQ[SPM_BIT_CLOCK_LAUNCH_PHASE];
				rateQ <= wDataQ[SPM_BIT_RATE_HI:SPM_BIT_RATE_LO];
			end
			if (wrData && !busy)
				txHoldQ <= wDataQ;
			if (byteDone)
				rxDataQ <= rxShD;
		end
	end

	// pin drive: master owns clock and mosi, a selected slave owns miso
	assign portEnable = portEnQ;
	assign sclkOut = sclkGenQ;
	assign sclkOe = masterMode;
	assign mosiOut = outBitQ;
	assign mosiOe = masterMode;
	assign misoOut = outBitQ;
	assign misoOe = slaveSel;
	assign transferDone = doneFlagQ;

	// assertion helpers
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			leadCntQ <= 4'h0;
		else if (clkEn)
			leadCntQ <= masterStart ? 4'h0 : (mLead ? leadCntQ + 4'h1 : leadCntQ);
	end

	sequence ssHighSeq;
		slaveMode && ssSync;
	endsequence

	sequence cpha0WaitSeq;
		clkEn && slaveMode && !cphaQ && (stateQ == SPM_WAIT_SS);
	endsequence

	done_flag_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		clkEn && byteDone |=> doneFlagQ && rxDataQ == $past(rxShD))
		else $error("byte end did not set flag and latch data");

	data_read_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		rdData && !byteDone |=> !doneFlagQ)
		else $error("data read did not clear done flag");

	collision_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		clkEn && wrData && busy |=> wcolQ && txHoldQ == $past(txHoldQ))
		else $error("busy write did not flag collision or changed held byte");

	burst_length_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		clkEn && masterDone |-> leadCntQ == SPM_BURST_CLOCKS)
		else $error("master burst not eight clocks");

	idle_level_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		masterMode && !busy && $stable(cpolQ) |-> sclkOut == cpolQ)
		else $error("serial clock not at idle level");

	ss_ignored_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ssHighSeq |-> !sampleEv && !launchEv && !misoOe)
		else $error("slave acted while deselected");

	ss_readback_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		clkEn && doRead && rHitCtrl && portEnQ && !masterQ |=> s_axi_rdata[0] == $past(ssSync))
		else $error("select level not reported in bit0");

	cpha0_end_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cpha0WaitSeq ##0 (ssRise && !doneClr) |=> doneFlagQ && stateQ == SPM_IDLE)
		else $error("slave byte not completed on select rising");

	master_start_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		clkEn && masterStart |=> busy && sclkOut == $past(cpolQ) && halfNumQ == 5'h00)
		else $error("master did not start burst");

endmodule

`default_nettype wire

// ===== core/spm_pkg.sv
// constants for the byte-wide serial peripheral port: register map, fields, resets, rates
// assumes an AXI4-Lite register bus with 32-bit data and a 100 MHz core clock as oscillator
//
// Behaviour
// - slave shifts only while select held low
// - slave mode: control bit0 reads select pin
// - done flag bit7 set after every byte
// - done flag cleared by zero write or data read
// - data write while busy sets sticky collision bit6
// - bit5 gives pins to this port or two-wire
// - bit4 selects master with clock output
// - bit3 sets serial clock idle level
// - bit2 chooses leading or trailing launch edge
// - master rate: /4, /8, /32, /64
// - data register: write sends, read receives, resets zero
// - master write emits exactly eight clock periods
// - master drives one bit, samples one, per period
// - master eighth clock: flag, latch received byte
// - master ignores the select input
// - slave write prepares byte; shifts on external clock
// - slave completes on eighth clock or select rising
// - eight bits, most significant first
// - launch on one edge, sample on other
package spm_pkg;

	// printed offsets are not word multiples, so they are indices; byte address is four times
	localparam logic [7:0] SPM_DATA_INDEX = 8'hF7;
	localparam logic [7:0] SPM_CTRL_INDEX = 8'hF8;
	localparam logic [9:0] SPM_DATA_ADDR = {SPM_DATA_INDEX, 2'h0};
	localparam logic [9:0] SPM_CTRL_ADDR = {SPM_CTRL_INDEX, 2'h0};

	localparam int SPM_BIT_DONE = 7;
	localparam int SPM_BIT_WRITE_COLLISION_FLAG = 6;
	localparam int SPM_BIT_PEN = 5;
	localparam int SPM_BIT_MST = 4;
	localparam int SPM_BIT_CLOCK_IDLE_LEVEL = 3;
	localparam int SPM_BIT_CLOCK_LAUNCH_PHASE = 2;
	localparam int SPM_BIT_RATE_HI = 1;
	localparam int SPM_BIT_RATE_LO = 0;

	localparam logic [7:0] SPM_CTRL_RESET = 8'h00;
	localparam logic [7:0] SPM_DATA_RESET = 8'h00;

	// oscillator divisors per rate code; the serial clock toggles every half of them
	localparam logic [6:0] SPM_DIV_4 = 7'h04;
	localparam logic [6:0] SPM_DIV_8 = 7'h08;
	localparam logic [6:0] SPM_DIV_32 = 7'h20;
	localparam logic [6:0] SPM_DIV_64 = 7'h40;

	localparam logic [3:0] SPM_LAST_BIT = 4'h7;
	localparam logic [4:0] SPM_LAST_HALF = 5'h0F;
	localparam logic [3:0] SPM_BURST_CLOCKS = 4'h8;

	localparam logic [1:0] SPM_RESP_OKAY = 2'h0;
	localparam logic [1:0] SPM_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0]
	{
		SPM_IDLE = 2'h0,
		SPM_RUN = 2'h1,
		SPM_WAIT_SS = 2'h3
	} spm_state_type;

endpackage

// ===== verification/spm_far_model.sv
// far-side partner: slave toward a master port, master toward a slave port
// assumes the bench resolves each pin from all enables and sets clock_idle_level/clock_launch_phase to match the port
`timescale 1ns/100ps
`default_nettype none

module spm_far_model
(
	input wire logic sclkPin,
	input wire logic mosiPin,
	input wire logic portIsMaster,
	input wire logic misoPin,
	input wire logic clock_idle_level,
	input wire logic clock_launch_phase,
	output var logic sclkDrv,
	output var logic mosiDrv,
	output var logic misoDrv,
	output var logic selN,
	output var logic [7:0] rxByte
);
	logic [7:0] txByte;
	int k;
	initial
	begin
		sclkDrv = 1'b0;
		mosiDrv = 1'b0;
		misoDrv = 1'b0;
		selN = 1'b1;
		rxByte = 8'h00;
		txByte = 8'h00;
		k = 8;
	end
	// slave role: sample on one edge, launch on the other, msb first
	always @(sclkPin)
		if (portIsMaster && ((sclkPin !== clock_idle_level) ^ clock_launch_phase))
			rxByte = {rxByte[6:0], mosiPin};
		else if (portIsMaster)
		begin
			misoDrv = (k < 8) ? txByte[7 - k] : ~misoDrv;
			k++;
		end
	task automatic load(input logic [7:0] b);
		txByte = b;
		k = clock_launch_phase ? 0 : 1;
		misoDrv = clock_launch_phase ? ~b[7] : b[7];
	endtask
	// master role at 80 ns per clock; clock rests at idle between frames
	task automatic xfer(input logic [7:0] b, input logic sel, input logic hold,
		output logic [7:0] r);
		sclkDrv = clock_idle_level;
		#40;
		selN = !sel;
		mosiDrv = b[7];
		for (int i = 0; i < 8; i++)
		begin
			#40;
			sclkDrv = ~clock_idle_level;
			if (clock_launch_phase)
				mosiDrv = b[7 - i];
			else
				r = {r[6:0], misoPin};
			#40;
			sclkDrv = clock_idle_level;
			if (clock_launch_phase)
				r = {r[6:0], misoPin};
			else if (i < 7)
				mosiDrv = b[6 - i];
		end
		#40;
		selN = !hold;
		mosiDrv = ~mosiDrv;
	endtask
endmodule
`default_nettype wire

// ===== verification/spm_serial_port_test.sv
// self-checking bench: register access, master bursts at all rates and modes, slave frames
// assumes the far-side model is compiled first; core clock 100 MHz, link clock 80 ns in slave frames, 40 to 640 ns in master bursts
`timescale 1ns/100ps
`default_nettype none

module spm_serial_port_test;
	import spm_pkg::*;
	localparam logic [11:0] CA = {2'h0, SPM_CTRL_ADDR};
	localparam logic [11:0] DA = {2'h0, SPM_DATA_ADDR};
	logic clk_sys = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h0, rdata;
	logic awready, wready, bvalid, arready, rvalid, sclkOut, sclkOe, mosiOut, mosiOe;
	logic misoOut, misoOe, portEnable, transferDone, sclkDrv, mosiDrv, misoDrv, selN;
	logic [1:0] bresp, rresp;
	logic [7:0] farRx, slvRx;
	logic clock_idle_level = 1'b0, clock_launch_phase = 1'b0, pSclk = 1'b0;
	int badCount = 0, cmpCount = 0, togg = 0, cyc = 0, first = 0, last = 0, tBase = 0;
	wire logic sclkW = sclkOe ? sclkOut : sclkDrv;
	wire logic mosiW = mosiOe ? mosiOut : mosiDrv;
	wire logic misoW = misoOe ? misoOut : misoDrv;

	spm_serial_port u_spm_serial_port (.clk_sys(clk_sys), .rst_n(rst_n), .clkEn(1'b1),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
		.sclkIn(sclkW), .sclkOut(sclkOut), .sclkOe(sclkOe), .mosiIn(mosiW), .mosiOut(mosiOut),
		.mosiOe(mosiOe), .misoIn(misoW), .misoOut(misoOut), .misoOe(misoOe),
		.slaveSelN(selN), .portEnable(portEnable), .transferDone(transferDone));
	spm_far_model u_spm_far_model (.sclkPin(sclkW), .mosiPin(mosiW), .portIsMaster(sclkOe),
		.misoPin(misoW), .clock_idle_level(clock_idle_level), .clock_launch_phase(clock_launch_phase), .sclkDrv(sclkDrv), .mosiDrv(mosiDrv),
		.misoDrv(misoDrv), .selN(selN), .rxByte(farRx));

	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		pSclk <= sclkOut;
		if (sclkOe && sclkOut !== pSclk)
		begin
			togg <= togg + 1;
			if (togg == tBase)
				first <= cyc;
			last <= cyc;
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp)
		begin
			badCount++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrapUp;
		if (badCount == 0 && cmpCount > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// bus tasks start just after a rising edge; handshakes are judged on the settled half cycle
	task automatic wr(input logic [11:0] a, input logic [7:0] v);
		logic ta, tw, tb;
		awaddr <= a;
		wdata <= {24'h0, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do
		begin
			@(negedge clk_sys);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			@(posedge clk_sys);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
		end
		while (!tb);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, tr;
		araddr <= a;
		arvalid <= 1'b1;
		do
		begin
			@(negedge clk_sys);
			ta = arvalid && arready;
			tr = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk_sys);
			if (ta)
				arvalid <= 1'b0;
		end
		while (!tr);
	endtask
	function automatic int expSpan(input logic [1:0] c);
		logic [6:0] divTab [4] = '{SPM_DIV_4, SPM_DIV_8, SPM_DIV_32, SPM_DIV_64};
		return 15 * int'(divTab[c]) / 2;
	endfunction

	initial
	begin
		#500000;
		badCount++;
		wrapUp;
	end
	initial
	begin
		logic [31:0] d;
		logic [1:0] r;
		logic [7:0] m, s;
		int n;
		void'($urandom(36));
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		rd(CA, d, r);
		chk(d, {24'h0, SPM_CTRL_RESET});
		rd(DA, d, r);
		chk(d, {24'h0, SPM_DATA_RESET});
		rd(12'h004, d, r);
		chk(r, SPM_RESP_SLVERR);
		wr(CA, 8'h10);
		chk({portEnable, sclkOe}, 0);
		for (int i = 0; i < 16; i++)
		begin
			clock_idle_level = i[2];
			clock_launch_phase = i[3];
			wr(CA, {4'h3, i[2], i[3], i[1:0]});
			repeat (2) @(posedge clk_sys);
			chk({portEnable, sclkOe, sclkW}, {2'h3, clock_idle_level});
			m = 8'($urandom);
			s = 8'($urandom);
			u_spm_far_model.load(s);
			tBase = togg;
			wr(DA, m);
			// a second write mid-burst must flag and leave the shifting byte alone
			if (i[1:0] == 2'h2)
				wr(DA, ~m);
			n = 0;
			do
			begin
				rd(CA, d, r);
				n++;
			end
			while (d[7] !== 1'b1 && n < 300);
			chk({transferDone, d[6]}, {1'b1, i[1:0] == 2'h2});
			chk(togg - tBase, 16);
			chk(last - first, expSpan(i[1:0]));
			rd(DA, d, r);
			chk(d, {24'h0, s});
			chk(farRx, m);
			rd(CA, d, r);
			chk(d[7], 0);
		end
		for (int i = 0; i < 4; i++)
		begin
			clock_idle_level = i[0];
			clock_launch_phase = i[1];
			wr(CA, {4'h2, i[0], i[1], 2'h0});
			rd(CA, d, r);
			chk({sclkOe, d[0]}, 1);
			u_spm_far_model.xfer(8'($urandom), 0, 0, slvRx);
			@(posedge clk_sys);
			rd(CA, d, r);
			chk(d[7], 0);
			for (int j = 0; j <= int'(clock_launch_phase); j++)
			begin
				m = 8'($urandom);
				s = 8'($urandom);
				wr(DA, s);
				u_spm_far_model.xfer(m, 1, clock_launch_phase && j == 0, slvRx);
				repeat (6) @(posedge clk_sys);
				rd(CA, d, r);
				chk(d[7], 1);
				chk(slvRx, s);
				wr(CA, {4'h2, i[0], i[1], 2'h0});
				rd(CA, d, r);
				chk(d[7], 0);
				rd(DA, d, r);
				chk(d, {24'h0, m});
			end
		end
		wrapUp;
	end
endmodule
`default_nettype wire
